// *** hdl/cipc_defs.svh ***
`ifndef CIPC_DEFS_SVH
`define CIPC_DEFS_SVH

// ----------------------------------------
// timing figures, as printed
// ----------------------------------------
`define CIPC_CLK_HZ        10000000
`define CIPC_DGL_MS        8
`define CIPC_BLANK_US      176
`define CIPC_OCOFF_MS      64
`define CIPC_RAMP_US       100
// ----------------------------------------
// derived cycle counts
// ----------------------------------------
`define CIPC_DGL_CYC       ((`CIPC_CLK_HZ / 1000) * `CIPC_DGL_MS)
`define CIPC_BLANK_CYC     ((`CIPC_CLK_HZ / 1000000) * `CIPC_BLANK_US)
`define CIPC_OCOFF_CYC     ((`CIPC_CLK_HZ / 1000) * `CIPC_OCOFF_MS)
`define CIPC_RAMP_CYC      ((`CIPC_CLK_HZ / 1000000) * `CIPC_RAMP_US)
// ----------------------------------------
// event limits and widths
// ----------------------------------------
`define CIPC_EVENT_LIMIT   15
`define CIPC_CNT_W         4
`define CIPC_TMR_W         24
`define CIPC_GATE_W        8
`define CIPC_GATE_FULL     8'hFF
`define CIPC_GATE_ZERO     8'h00

`endif

// *** hdl/cipc_pkg.sv ***
`default_nettype none

package cipc_pkg;

  // ----------------------------------------
  // comparator flags from the analog front
  // ----------------------------------------
  typedef struct packed {
    logic inputAboveLockout;
    logic inputOvervoltage;
    logic overcurrentLimit;
    logic batteryOvervoltage;
    logic dieOvertemp;
  } cipc_flags_type;

  typedef enum logic [6:0] {
    ST_DOWN  = 7'h01,
    ST_DGL   = 7'h02,
    ST_ON    = 7'h04,
    ST_OCOFF = 7'h08,
    ST_WAIT  = 7'h10,
    ST_OVREC = 7'h20,
    ST_LATCH = 7'h40
  } cipc_state_type;

endpackage : cipc_pkg

`default_nettype wire

// *** hdl/cipc_soft_ramp.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cipc_defs.svh"

module cipc_soft_ramp #(
  parameter int STEP_CYC = `CIPC_RAMP_CYC
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // control
  input  wire logic                    closeReq,
  input  wire logic                    fastOff,
  // gate drive
  output logic [`CIPC_GATE_W-1:0]      gateLevel
);

  // step divider must fit the shared timer width
  if (STEP_CYC < 1 || STEP_CYC >= (1 << `CIPC_TMR_W)) begin : gBadStep
    $error("STEP_CYC out of range");
  end

  logic [`CIPC_TMR_W-1:0] div_r;
  logic [`CIPC_TMR_W-1:0] div_nxt;
  logic [`CIPC_GATE_W-1:0] level_r;
  logic [`CIPC_GATE_W-1:0] level_nxt;
  logic                    stepEn;

  always_comb begin
    stepEn    = (div_r == `CIPC_TMR_W'(STEP_CYC - 1));
    div_nxt   = stepEn ? '0 : div_r + 1'b1;
    level_nxt = level_r;
    // abrupt open on input overvoltage
    if (fastOff) begin
      level_nxt = `CIPC_GATE_ZERO;
    end else if (stepEn && closeReq && level_r != `CIPC_GATE_FULL) begin
      level_nxt = level_r + 1'b1;
    end else if (stepEn && !closeReq && level_r != `CIPC_GATE_ZERO) begin
      level_nxt = level_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_r   <= '0;
      level_r <= `CIPC_GATE_ZERO;
    end else begin
      div_r   <= div_nxt;
      level_r <= level_nxt;
    end
  end

  assign gateLevel = level_r;

endmodule : cipc_soft_ramp

`default_nettype wire

// *** hdl/cipc_ctrl.sv ***
// How it works
// (RULE1) below lockout: switch open, fault released
// (RULE2) rising past lockout resets all state
// (RULE3) after deglitch close only if safe
// (RULE4) every close ramps on gradually
// (RULE5) overvoltage during deglitch: never close, fault
// (RULE6) input overvoltage opens switch at once
// (RULE7) overvoltage clears: wait recovery, reclose
// (RULE8) overcurrent starts blanking; short ones ignored
// (RULE9) persistent overcurrent: off time, then retry
// (RULE10) fifteenth overcurrent shutdown latches off
// (RULE11) overcurrent shutdown opens switch slowly
// (RULE12) battery overvoltage: soft open, fault low
// (RULE13) battery below hysteresis: reclose switch
// (RULE14) separate battery counter, fifteenth latches off
// (RULE15) disable or power cycle clears counters
// (RULE16) overtemperature opens switch until cooled
// (RULE17) high enable forces switch open
// (RULE18) floating enable counts as enabled
// (RULE19) fault released when disabled, or when safe outside off time and latch
// (RULE20) fault low for four fault kinds
// (RULE21) 8 ms deglitch and recovery interval
// (RULE22) 176 us overcurrent blanking interval
// (RULE23) 64 ms off time after overcurrent
// (RULE24) flags in, timers from internal base
`timescale 1ns/1ps
`default_nettype none
`include "cipc_defs.svh"

module cipc_ctrl #(
  parameter int DGL_CYC   = `CIPC_DGL_CYC,
  parameter int BLANK_CYC = `CIPC_BLANK_CYC,
  parameter int OCOFF_CYC = `CIPC_OCOFF_CYC,
  parameter int RAMP_CYC  = `CIPC_RAMP_CYC
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // comparator flags, asynchronous
  input  wire cipc_pkg::cipc_flags_type flagsIn,
  // host enable, active low
  input  wire logic                    enableIn_n,
  input  wire logic                    enableFloat,
  // pass switch drive
  output logic                         switchClosed,
  output logic [`CIPC_GATE_W-1:0]      passSwitchGate,
  // open-drain fault pin
  output logic                         faultOut,
  output logic                         faultOe
);

  if (DGL_CYC < 1 || DGL_CYC >= (1 << `CIPC_TMR_W)) begin : gBadDgl
    $error("DGL_CYC out of range");
  end
  if (BLANK_CYC < 1 || BLANK_CYC >= (1 << `CIPC_TMR_W)) begin : gBadBlank
    $error("BLANK_CYC out of range");
  end
  if (OCOFF_CYC < 1 || OCOFF_CYC >= (1 << `CIPC_TMR_W)) begin : gBadOcoff
    $error("OCOFF_CYC out of range");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  cipc_pkg::cipc_flags_type fMeta_r;
  cipc_pkg::cipc_flags_type f_r;
  logic [1:0]               enMeta_r;
  logic [1:0]               en_r;

  // (RULE24) comparator flags synced in
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fMeta_r  <= '0;
      f_r      <= '0;
      enMeta_r <= 2'h0;
      en_r     <= 2'h0;
    end else begin
      fMeta_r  <= flagsIn;
      f_r      <= fMeta_r;
      enMeta_r <= {enableFloat, enableIn_n};
      en_r     <= enMeta_r;
    end
  end

  logic disabled;
  logic inputOk;
  // (RULE18) floating pin reads as enabled
  assign disabled = en_r[0] && !en_r[1];
  assign inputOk  = f_r.inputAboveLockout;

  // ----------------------------------------
  // control state machine
  // ----------------------------------------
  cipc_pkg::cipc_state_type state_r;
  cipc_pkg::cipc_state_type state_nxt;
  logic [`CIPC_TMR_W-1:0]   tmr_r;
  logic [`CIPC_TMR_W-1:0]   tmr_nxt;
  logic [`CIPC_CNT_W-1:0]   ocCnt_r;
  logic [`CIPC_CNT_W-1:0]   ocCnt_nxt;
  logic [`CIPC_CNT_W-1:0]   bvCnt_r;
  logic [`CIPC_CNT_W-1:0]   bvCnt_nxt;
  logic                     bvPrev_r;
  logic                     bvPrev_nxt;
  logic                     disPrev_r;
  logic                     faultOe_r;
  logic                     faultOe_nxt;
  logic                     closed_r;
  logic                     closed_nxt;
  logic                     fastOff_r;
  logic                     fastOff_nxt;
  logic                     safe;
  logic                     bvRise;

  function automatic logic [`CIPC_TMR_W-1:0] cycLast(input int cyc);
    cycLast = `CIPC_TMR_W'(cyc - 1);
  endfunction : cycLast

  // (RULE16) hot die counts unsafe
  assign safe   = !f_r.inputOvervoltage && !f_r.batteryOvervoltage && !f_r.dieOvertemp;
  assign bvRise = f_r.batteryOvervoltage && !bvPrev_r;

  always_comb begin
    state_nxt  = state_r;
    tmr_nxt    = tmr_r;
    ocCnt_nxt  = ocCnt_r;
    bvCnt_nxt  = bvCnt_r;
    bvPrev_nxt = f_r.batteryOvervoltage;
    case (state_r)
      cipc_pkg::ST_DOWN: begin
        // (RULE2) lockout release restarts all
        if (inputOk) begin
          state_nxt = cipc_pkg::ST_DGL;
          tmr_nxt   = '0;
        end
      end
      cipc_pkg::ST_DGL: begin
        // (RULE21) deglitch wait counts
        tmr_nxt = tmr_r + 1'b1;
        // (RULE5) early overvoltage blocks power-up
        if (f_r.inputOvervoltage) begin
          state_nxt = cipc_pkg::ST_WAIT;
        end else if (tmr_r == cycLast(DGL_CYC)) begin
          // (RULE3) close only when inputs safe
          state_nxt = (safe && !disabled) ? cipc_pkg::ST_ON : cipc_pkg::ST_WAIT;
          tmr_nxt   = '0;
        end
      end
      cipc_pkg::ST_ON: begin
        // (RULE8) blanking runs while limited
        // (RULE22) blanking interval count
        tmr_nxt = f_r.overcurrentLimit ? tmr_r + 1'b1 : '0;
        if (f_r.inputOvervoltage) begin
          state_nxt = cipc_pkg::ST_WAIT;
        end else if (disabled || !safe) begin
          state_nxt = cipc_pkg::ST_WAIT;
        end else if (f_r.overcurrentLimit && tmr_r == cycLast(BLANK_CYC)) begin
          // (RULE10) count shutdowns, latch at limit
          ocCnt_nxt = ocCnt_r + 1'b1;
          state_nxt = (ocCnt_nxt == `CIPC_CNT_W'(`CIPC_EVENT_LIMIT)) ? cipc_pkg::ST_LATCH : cipc_pkg::ST_OCOFF;
          tmr_nxt   = '0;
        end
      end
      cipc_pkg::ST_OCOFF: begin
        // (RULE23) fixed off time, then retry
        // (RULE9) switch off, fault held
        tmr_nxt = tmr_r + 1'b1;
        if (tmr_r == cycLast(OCOFF_CYC)) begin
          state_nxt = cipc_pkg::ST_WAIT;
          tmr_nxt   = '0;
        end
      end
      cipc_pkg::ST_WAIT: begin
        tmr_nxt = '0;
        // (RULE7) overvoltage cleared: recovery wait
        // (RULE13) battery cleared: reclose path
        if (!f_r.inputOvervoltage && safe && !disabled) begin
          state_nxt = cipc_pkg::ST_OVREC;
        end
      end
      cipc_pkg::ST_OVREC: begin
        tmr_nxt = tmr_r + 1'b1;
        if (!safe || disabled) begin
          state_nxt = cipc_pkg::ST_WAIT;
        end else if (tmr_r == cycLast(DGL_CYC)) begin
          state_nxt = cipc_pkg::ST_ON;
          tmr_nxt   = '0;
        end
      end
      cipc_pkg::ST_LATCH: begin
        tmr_nxt = '0;
      end
      default: begin
        state_nxt = cipc_pkg::ST_DOWN;
      end
    endcase
    // (RULE14) battery events counted apart
    if (bvRise && state_r != cipc_pkg::ST_DOWN && state_r != cipc_pkg::ST_LATCH) begin
      bvCnt_nxt = bvCnt_r + 1'b1;
      if (bvCnt_nxt == `CIPC_CNT_W'(`CIPC_EVENT_LIMIT)) begin
        state_nxt = cipc_pkg::ST_LATCH;
      end
    end
    // (RULE15) disable clears counters and latch
    if (disabled) begin
      ocCnt_nxt = '0;
      bvCnt_nxt = '0;
      if (state_r == cipc_pkg::ST_LATCH) begin
        state_nxt = cipc_pkg::ST_WAIT;
      end
    end
    // (RULE1) lockout overrides everything
    if (!inputOk) begin
      state_nxt = cipc_pkg::ST_DOWN;
      tmr_nxt   = '0;
      ocCnt_nxt = '0;
      bvCnt_nxt = '0;
    end
  end

  // ----------------------------------------
  // output decode
  // ----------------------------------------
  always_comb begin
    // (RULE17) enable gates the close request
    closed_nxt  = (state_nxt == cipc_pkg::ST_ON) && !disabled;
    // (RULE6) overvoltage opens without ramp
    fastOff_nxt = f_r.inputOvervoltage || !inputOk;
    // (RULE20) fault on any of four kinds
    // (RULE19) released when disabled, or when safe outside off time and latch
    faultOe_nxt = inputOk && !disabled &&
                  (!safe || state_nxt == cipc_pkg::ST_OCOFF || state_nxt == cipc_pkg::ST_LATCH);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r   <= cipc_pkg::ST_DOWN;
      tmr_r     <= '0;
      ocCnt_r   <= '0;
      bvCnt_r   <= '0;
      bvPrev_r  <= 1'b0;
      disPrev_r <= 1'b0;
      faultOe_r <= 1'b0;
      closed_r  <= 1'b0;
      fastOff_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      tmr_r     <= tmr_nxt;
      ocCnt_r   <= ocCnt_nxt;
      bvCnt_r   <= bvCnt_nxt;
      bvPrev_r  <= bvPrev_nxt;
      disPrev_r <= disabled;
      faultOe_r <= faultOe_nxt;
      closed_r  <= closed_nxt;
      fastOff_r <= fastOff_nxt;
    end
  end

  // ----------------------------------------
  // gate ramp
  // ----------------------------------------
  logic [`CIPC_GATE_W-1:0] rampLevel;

  // (RULE4) soft-start on every close
  // (RULE11) soft-stop on current shutdown
  // (RULE12) battery fault opens gradually
  cipc_soft_ramp #(
    .STEP_CYC (RAMP_CYC)
  ) uRamp (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .closeReq  (closed_r),
    .fastOff   (fastOff_r),
    .gateLevel (rampLevel)
  );

  // gate register keeps the output straight from a flop
  logic [`CIPC_GATE_W-1:0] gate_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      gate_r <= `CIPC_GATE_ZERO;
    end else begin
      gate_r <= fastOff_r ? `CIPC_GATE_ZERO : rampLevel;
    end
  end

  assign switchClosed   = closed_r;
  assign passSwitchGate = gate_r;
  assign faultOut       = 1'b0;
  assign faultOe        = faultOe_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence ocBlankRun;
    (state_r == cipc_pkg::ST_ON && tmr_r == cycLast(BLANK_CYC) && f_r.overcurrentLimit && safe && !disabled
     && inputOk);
  endsequence

  chk_lockout_open: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
    !inputOk |=> !closed_r && !faultOe_r) else $error("switch or fault active below lockout");
  chk_restart_counts: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE2
    $rose(inputOk) |-> ocCnt_r == '0 && bvCnt_r == '0) else $error("counters not reset at power-up");
  chk_ov_fast: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
    f_r.inputOvervoltage |=> fastOff_r ##1 gate_r == `CIPC_GATE_ZERO) else $error("overvoltage open not immediate");
  chk_ov_never: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
    (state_r == cipc_pkg::ST_DGL && f_r.inputOvervoltage && inputOk) |=> state_r == cipc_pkg::ST_WAIT)
    else $error("overvoltage in deglitch not caught");
  chk_oc_shutdown: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE9
    ocBlankRun |=> (state_r == cipc_pkg::ST_OCOFF || state_r == cipc_pkg::ST_LATCH)) else $error("no shutdown");
  chk_latch_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
    ocBlankRun ##0 (ocCnt_r == `CIPC_CNT_W'(`CIPC_EVENT_LIMIT - 1)) |=> state_r == cipc_pkg::ST_LATCH)
    else $error("fifteenth shutdown did not latch");
  chk_reenable_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE15
    (disPrev_r && !disabled) |-> ocCnt_r == '0 && bvCnt_r == '0 && state_r != cipc_pkg::ST_LATCH)
    else $error("re-enable left counters or latch");
  chk_enable_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE17
    disabled |=> !closed_r && !faultOe_r) else $error("disabled device still active");
  chk_clear_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE15
    disabled |=> ocCnt_r == '0 && bvCnt_r == '0) else $error("disable did not clear counters");
  chk_fault_kinds: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE20
    (inputOk && !disabled && f_r.dieOvertemp) |=> faultOe_r) else $error("fault not driven on overtemp");

endmodule : cipc_ctrl

`default_nettype wire

// *** tb/cipc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cipc_host_model (
  // clock
  input  wire logic sys_clk,
  // device side
  input  wire logic faultOut,
  input  wire logic faultOe,
  output logic      enableIn_n,
  output logic      enableFloat,
  // host view of the fault line
  output logic      faultPin
);
  // ----------------------------------------
  // open-drain line with board pull-up
  // ----------------------------------------
  assign faultPin = faultOe ? faultOut : 1'b1;

  initial begin
    enableIn_n  = 1'b0;
    enableFloat = 1'b0;
  end

  // ----------------------------------------
  // enable drive
  // ----------------------------------------
  // host drives enable on, off or floating
  task automatic set_enable(input logic on, input logic floatPin);
    @(posedge sys_clk);
    #1;
    enableFloat = floatPin;
    // a floating pin shows the unkind level, not the pulled one
    enableIn_n  = floatPin ? 1'b1 : !on;
  endtask : set_enable
endmodule : cipc_host_model

`default_nettype wire

// *** tb/tb_charger_input_protection_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_charger_input_protection_ctrl;
  localparam int DGL = 20;
  localparam int BLANK = 5;
  localparam int OCOFF = 30;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                     sys_clk;
  logic                     rst_n;
  cipc_pkg::cipc_flags_type flags;
  logic                     enableIn_n;
  logic                     enableFloat;
  logic                     switchClosed;
  logic [7:0]               gate;
  logic                     faultOut;
  logic                     faultOe;
  logic                     faultPin;
  int                       fail_count;
  int                       check_count;
  int                       cycles;
  int                       n;

  cipc_ctrl #(.DGL_CYC(DGL), .BLANK_CYC(BLANK), .OCOFF_CYC(OCOFF), .RAMP_CYC(1)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .flagsIn(flags), .enableIn_n(enableIn_n),
    .enableFloat(enableFloat), .switchClosed(switchClosed), .passSwitchGate(gate),
    .faultOut(faultOut), .faultOe(faultOe));

  cipc_host_model host (
    .sys_clk(sys_clk), .faultOut(faultOut), .faultOe(faultOe),
    .enableIn_n(enableIn_n), .enableFloat(enableFloat), .faultPin(faultPin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #50 sys_clk = !sys_clk;

  // hang guard, well above the whole run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic check(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %b expected %b", $time, seen, exp);
    end
  endtask : check

  // sel 0 watches the switch, sel 1 the fault pin pulled low
  task automatic wait_out(input logic sel, input logic v, input int lim);
    n = 0;
    while ((sel ? !faultPin : switchClosed) !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask : wait_out

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_powerup();
    tick(10);
    check(switchClosed, 1'b0);
    check(faultPin, 1'b1);
    flags.inputAboveLockout = 1'b1;
    wait_out(0, 1, DGL + 40);
    check(n >= DGL && n <= DGL + 8, 1'b1);
    tick(2);
    check(gate != 8'hFF && gate != 8'h00, 1'b1);
    tick(260);
    check(gate === 8'hFF, 1'b1);
    $display("powerup done");
  endtask : test_powerup

  task automatic test_overvolt();
    flags.inputOvervoltage = 1'b1;
    wait_out(1, 1, 10);
    tick(2);
    check(gate === 8'h00 && !switchClosed, 1'b1);
    flags.inputOvervoltage = 1'b0;
    wait_out(0, 1, DGL + 40);
    check(n >= DGL && n <= DGL + 8, 1'b1);
    check(faultPin, 1'b1);
    $display("overvolt done");
  endtask : test_overvolt

  task automatic test_overcurrent();
    tick(260);
    flags.overcurrentLimit = 1'b1;
    tick(BLANK - 2);
    flags.overcurrentLimit = 1'b0;
    tick(10);
    check(switchClosed && faultPin, 1'b1);
    for (int i = 1; i <= 15; i++) begin
      flags.overcurrentLimit = 1'b1;
      wait_out(1, 1, BLANK + 20);
      if (i == 1) check(n >= BLANK && n <= BLANK + 8, 1'b1);
      // an abrupt open would reach zero within these three edges
      tick(3);
      check(gate != 8'h00 && gate != 8'hFF, 1'b1);
      flags.overcurrentLimit = 1'b0;
      wait_out(0, 1, 1000);
      if (i == 1) check(n >= OCOFF, 1'b1);
      check(switchClosed, i < 15);
    end
    check(faultPin, 1'b0);
    host.set_enable(1'b0, 1'b0);
    tick(8);
    check(faultPin && !switchClosed, 1'b1);
    host.set_enable(1'b1, 1'b0);
    wait_out(0, 1, DGL + 300);
    check(switchClosed, 1'b1);
    $display("overcurrent done");
  endtask : test_overcurrent

  task automatic test_battery();
    for (int i = 1; i <= 15; i++) begin
      tick(260);
      flags.batteryOvervoltage = 1'b1;
      wait_out(1, 1, 20);
      tick(3);
      check(gate != 8'h00 && gate != 8'hFF, 1'b1);
      flags.batteryOvervoltage = 1'b0;
      wait_out(0, 1, DGL + 300);
      check(switchClosed, i < 15);
    end
    flags.inputAboveLockout = 1'b0;
    tick(8);
    check(faultPin && !switchClosed, 1'b1);
    flags.inputAboveLockout = 1'b1;
    flags.inputOvervoltage = 1'b1;
    wait_out(0, 1, DGL + 40);
    check(switchClosed || faultPin, 1'b0);
    flags.inputOvervoltage = 1'b0;
    wait_out(0, 1, DGL + 300);
    check(switchClosed, 1'b1);
    $display("battery done");
  endtask : test_battery

  task automatic test_thermal_enable();
    flags.dieOvertemp = 1'b1;
    wait_out(1, 1, 20);
    check(switchClosed, 1'b0);
    flags.dieOvertemp = 1'b0;
    wait_out(0, 1, DGL + 300);
    check(switchClosed && faultPin, 1'b1);
    host.set_enable(1'b0, 1'b0);
    flags.dieOvertemp = 1'b1;
    tick(10);
    check(!switchClosed && faultPin, 1'b1);
    flags.dieOvertemp = 1'b0;
    host.set_enable(1'b0, 1'b1);
    wait_out(0, 1, DGL + 300);
    check(switchClosed, 1'b1);
    $display("thermal enable done");
  endtask : test_thermal_enable

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    flags = '0;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    tick(4);
    rst_n = 1'b1;
    test_powerup();
    test_overvolt();
    test_overcurrent();
    test_battery();
    test_thermal_enable();
    stop_test();
  end
endmodule : tb_charger_input_protection_ctrl

`default_nettype wire
